// >>> core/wcel_pkg.sv
`default_nettype none
package wcel_pkg;
    localparam int NCH = 8;
    localparam int CODE_W = 12;
    localparam int HYST_W = 4;
    localparam int CNT_W = 4;
    localparam int CH_W = 3;
    localparam int OUT_W = 16;
    // Channel comparator defaults after reset
    localparam logic [CODE_W-1:0] THR_HI_RST = 12'hFFF;
    localparam logic [CODE_W-1:0] THR_LO_RST = 12'h000;
    localparam logic [HYST_W-1:0] HYST_RST = 4'h0;
    localparam logic [CNT_W-1:0] EVCNT_RST = 4'h0;
    localparam logic [CODE_W-1:0] CODE_MAX = 12'hFFF;
    localparam logic [CNT_W-1:0] CNT_MAX = 4'hF;
    // Append selection codes
    localparam logic [1:0] APPEND_NONE = 2'b00;
    localparam logic [1:0] APPEND_CHID = 2'b01;
    localparam logic [1:0] APPEND_FLAGS = 2'b10;
    // Fixed leading pair of the appended status nibble
    localparam logic [1:0] STATUS_FIXED = 2'b10;

    typedef struct packed {
        logic [CODE_W-1:0] hiThr;
        logic [CODE_W-1:0] loThr;
        logic [HYST_W-1:0] hyst;
        logic [CNT_W-1:0] evCount;
    } wcel_chcfg_s;

    localparam wcel_chcfg_s CHCFG_RST = '{hiThr: THR_HI_RST, loThr: THR_LO_RST, hyst: HYST_RST, evCount: EVCNT_RST};

    typedef struct packed {
        logic valid;
        logic [CH_W-1:0] channel;
        logic [CODE_W-1:0] code;
    } wcel_conv_s;

    typedef struct packed {
        logic [CODE_W-1:0] minCode;
        logic [CODE_W-1:0] maxCode;
        logic [CODE_W-1:0] lastCode;
    } wcel_stat_s;

    typedef struct packed {
        logic valid;
        logic [CH_W-1:0] channel;
        wcel_stat_s data;
    } wcel_statwr_s;
endpackage
`default_nettype wire

// >>> core/wcel_stat_mem.sv
`default_nettype none
module wcel_stat_mem (
    input wire logic clk, // Clock
    input wire logic wrEn, // Write strobe
    input wire logic [wcel_pkg::CH_W-1:0] wrAddr, // Write channel
    input wire wcel_pkg::wcel_stat_s wrData, // Write entry
    input wire logic [wcel_pkg::CH_W-1:0] rdAddrA, // Update-side read channel
    output wcel_pkg::wcel_stat_s rdDataA, // Update-side read entry
    input wire logic [wcel_pkg::CH_W-1:0] rdAddrB, // Host-side read channel
    output wcel_pkg::wcel_stat_s rdDataB // Host-side read entry
);
    wcel_pkg::wcel_stat_s mem [wcel_pkg::NCH];
    wcel_pkg::wcel_stat_s rdA_q;
    wcel_pkg::wcel_stat_s rdB_q;

    // Read-before-write; the caller forwards same-channel updates
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdA_q <= mem[rdAddrA];
        rdB_q <= mem[rdAddrB];
    end

    assign rdDataA = rdA_q;
    assign rdDataB = rdB_q;
endmodule
`default_nettype wire

// >>> core/wcel_event_logic.sv
`default_nettype none
module wcel_event_logic (
    input wire logic clk, // 200 MHz clock
    input wire logic rst, // Async reset, active high
    input wire wcel_pkg::wcel_conv_s conv, // Conversion result strobe
    input wire logic [1:0] appendSelect, // Appended nibble choice
    input wire logic inputCrcError, // Input CRC error flag
    input wire logic windowComparatorEnable, // Comparator enable
    input wire logic cfgWrite, // Channel threshold write strobe
    input wire logic [wcel_pkg::CH_W-1:0] cfgChannel, // Channel written
    input wire wcel_pkg::wcel_chcfg_s cfgData, // Threshold settings written
    input wire logic [wcel_pkg::NCH-1:0] regionSelect, // Band or edge direction
    input wire logic [wcel_pkg::NCH-1:0] pinIsDigital, // Channel is digital
    input wire logic [wcel_pkg::NCH-1:0] digitalIsOutput, // Digital channel drives
    input wire logic [wcel_pkg::NCH-1:0] outputPushPull, // Digital output drive type
    input wire logic [wcel_pkg::NCH-1:0] highFlagClear, // Write-one clear, high flags
    input wire logic [wcel_pkg::NCH-1:0] lowFlagClear, // Write-one clear, low flags
    input wire logic [wcel_pkg::NCH-1:0] notifyChannelSelect, // Notify enables
    input wire logic notifyPushPull, // Notify pin drive type
    input wire logic [wcel_pkg::NCH-1:0][wcel_pkg::NCH-1:0] outputTriggerSelect, // Per-output trigger set
    input wire logic [wcel_pkg::NCH-1:0] outputDefaultValue, // Idle output values
    input wire logic [wcel_pkg::NCH-1:0] outputTriggeredValue, // Event output values
    input wire logic [wcel_pkg::NCH-1:0] outputTriggerEnable, // Event update enables
    input wire logic statisticsEnable, // Statistics recording level
    input wire logic statisticsEnableWrite, // Pulse: one written to enable
    input wire logic [wcel_pkg::CH_W-1:0] statReadChannel, // Statistics read channel
    input wire logic [wcel_pkg::NCH-1:0] gpioIn, // Channel pin levels
    output logic [wcel_pkg::NCH-1:0] gpioOut, // Channel pin output values
    output logic [wcel_pkg::NCH-1:0] gpioOe, // Channel pin drive enables
    output logic notifyOut, // Notify pin value, low when asserted
    output logic notifyOe, // Notify pin drive enable
    output logic [wcel_pkg::NCH-1:0] highFlag, // High event flags
    output logic [wcel_pkg::NCH-1:0] lowFlag, // Low event flags
    output logic [wcel_pkg::NCH-1:0] eventFlag, // Combined event flags
    output logic outValid, // Output word strobe
    output logic [wcel_pkg::OUT_W-1:0] outData, // Result with nibble appended
    output wcel_pkg::wcel_stat_s statReadData, // Statistics of read channel
    output logic [wcel_pkg::NCH-1:0] statValid // Channel has statistics
);
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic hitHigh(input logic [wcel_pkg::CODE_W-1:0] code,
                                     input wcel_pkg::wcel_chcfg_s c, input logic active);
        logic [wcel_pkg::CODE_W-1:0] h;
        logic [wcel_pkg::CODE_W-1:0] thr;
        h = {{(wcel_pkg::CODE_W-wcel_pkg::HYST_W){1'b0}}, c.hyst};
        // Once raised, the level must fall below threshold minus hysteresis
        thr = !active ? c.hiThr : (c.hiThr > h) ? c.hiThr - h : '0;
        return code > thr;
    endfunction

    function automatic logic hitLow(input logic [wcel_pkg::CODE_W-1:0] code,
                                    input wcel_pkg::wcel_chcfg_s c, input logic active);
        logic [wcel_pkg::CODE_W-1:0] h;
        logic [wcel_pkg::CODE_W-1:0] thr;
        h = {{(wcel_pkg::CODE_W-wcel_pkg::HYST_W){1'b0}}, c.hyst};
        thr = !active ? c.loThr : (c.loThr > wcel_pkg::CODE_MAX - h) ? wcel_pkg::CODE_MAX : c.loThr + h;
        return code < thr;
    endfunction

    function automatic logic [wcel_pkg::CNT_W-1:0] satInc(input logic [wcel_pkg::CNT_W-1:0] v);
        return (v == wcel_pkg::CNT_MAX) ? v : v + 4'h1;
    endfunction

    // ************************************************************
    // Pin synchroniser
    // ************************************************************
    logic [wcel_pkg::NCH-1:0] gpioMeta_q, gpioSync_q, gpioPrev_q;
    logic [wcel_pkg::NCH-1:0] isDigIn, rise, fall;
    logic [2:0] edgeArm_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gpioMeta_q <= '0;
            gpioSync_q <= '0;
            gpioPrev_q <= '0;
            edgeArm_q <= 3'h0;
        end else begin
            gpioMeta_q <= gpioIn;
            gpioSync_q <= gpioMeta_q;
            gpioPrev_q <= gpioSync_q;
            edgeArm_q <= {edgeArm_q[1:0], 1'b1};
        end
    end

    assign isDigIn = pinIsDigital & ~digitalIsOutput;
    // Edges held off until the chain holds real pin levels, not reset zeros
    assign rise = gpioSync_q & ~gpioPrev_q & {wcel_pkg::NCH{edgeArm_q[2]}};
    assign fall = ~gpioSync_q & gpioPrev_q & {wcel_pkg::NCH{edgeArm_q[2]}};

    // ************************************************************
    // Channel configuration
    // ************************************************************
    wcel_pkg::wcel_chcfg_s chCfg_q [wcel_pkg::NCH];
    wcel_pkg::wcel_chcfg_s chCfg_d [wcel_pkg::NCH];

    always_comb begin
        for (int i = 0; i < wcel_pkg::NCH; i++) begin
            chCfg_d[i] = chCfg_q[i];
        end
        if (cfgWrite) begin
            chCfg_d[cfgChannel] = cfgData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < wcel_pkg::NCH; i++) begin
                chCfg_q[i] <= wcel_pkg::CHCFG_RST;
            end
        end else begin
            chCfg_q <= chCfg_d;
        end
    end

    // ************************************************************
    // Window comparator and event flags
    // ************************************************************
    logic [wcel_pkg::NCH-1:0] hiFlag_q, hiFlag_d, loFlag_q, loFlag_d;
    logic [wcel_pkg::CNT_W-1:0] hiCnt_q [wcel_pkg::NCH];
    logic [wcel_pkg::CNT_W-1:0] hiCnt_d [wcel_pkg::NCH];
    logic [wcel_pkg::CNT_W-1:0] loCnt_q [wcel_pkg::NCH];
    logic [wcel_pkg::CNT_W-1:0] loCnt_d [wcel_pkg::NCH];
    wcel_pkg::wcel_chcfg_s cc;
    logic vHi, vLo, inBand;

    always_comb begin
        hiFlag_d = hiFlag_q & ~highFlagClear;
        loFlag_d = loFlag_q & ~lowFlagClear;
        hiCnt_d = hiCnt_q;
        loCnt_d = loCnt_q;
        cc = chCfg_q[conv.channel];
        inBand = (conv.code <= cc.hiThr) && (conv.code >= cc.loThr);
        vHi = 1'b0;
        vLo = 1'b0;
        // Sets follow clears so an event in the clear cycle survives
        for (int i = 0; i < wcel_pkg::NCH; i++) begin
            if (isDigIn[i] && !regionSelect[i] && rise[i]) begin
                hiFlag_d[i] = 1'b1;
            end
            if (isDigIn[i] && regionSelect[i] && fall[i]) begin
                loFlag_d[i] = 1'b1;
            end
        end
        if (conv.valid && windowComparatorEnable && !pinIsDigital[conv.channel]) begin
            if (regionSelect[conv.channel]) begin
                vHi = inBand;
                vLo = inBand;
            end else begin
                vHi = hitHigh(conv.code, cc, hiFlag_q[conv.channel]);
                vLo = hitLow(conv.code, cc, loFlag_q[conv.channel]);
            end
            if (vHi) begin
                hiCnt_d[conv.channel] = satInc(hiCnt_q[conv.channel]);
                if (hiCnt_q[conv.channel] >= cc.evCount) begin
                    hiFlag_d[conv.channel] = 1'b1;
                end
            end else begin
                hiCnt_d[conv.channel] = '0;
            end
            if (vLo) begin
                loCnt_d[conv.channel] = satInc(loCnt_q[conv.channel]);
                if (loCnt_q[conv.channel] >= cc.evCount) begin
                    loFlag_d[conv.channel] = 1'b1;
                end
            end else begin
                loCnt_d[conv.channel] = '0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hiFlag_q <= '0;
            loFlag_q <= '0;
            for (int i = 0; i < wcel_pkg::NCH; i++) begin
                hiCnt_q[i] <= '0;
                loCnt_q[i] <= '0;
            end
        end else begin
            hiFlag_q <= hiFlag_d;
            loFlag_q <= loFlag_d;
            hiCnt_q <= hiCnt_d;
            loCnt_q <= loCnt_d;
        end
    end

    assign highFlag = hiFlag_q;
    assign lowFlag = loFlag_q;
    assign eventFlag = hiFlag_q | loFlag_q;

    // ************************************************************
    // Output word, notify pin, digital outputs
    // ************************************************************
    logic outValid_q, outValid_d;
    logic [wcel_pkg::OUT_W-1:0] outData_q, outData_d;
    logic notifyOut_q, notifyOut_d, notifyOe_q, notifyOe_d;
    logic [wcel_pkg::NCH-1:0] gpoVal_q, gpoVal_d, gpoOe_q, gpoOe_d;
    logic notifyAct;

    always_comb begin
        outValid_d = conv.valid;
        outData_d = outData_q;
        if (conv.valid) begin
            unique case (appendSelect)
                wcel_pkg::APPEND_FLAGS: outData_d = {conv.code, wcel_pkg::STATUS_FIXED, inputCrcError, |eventFlag};
                wcel_pkg::APPEND_CHID: outData_d = {conv.code, 1'b0, conv.channel};
                default: outData_d = {conv.code, 4'h0};
            endcase
        end
        notifyAct = |(eventFlag & notifyChannelSelect);
        // Low when asserted; open-drain only pulls, never drives high
        notifyOut_d = ~notifyAct;
        notifyOe_d = notifyPushPull | notifyAct;
        for (int i = 0; i < wcel_pkg::NCH; i++) begin
            if (outputTriggerEnable[i] && |(outputTriggerSelect[i] & eventFlag)) begin
                gpoVal_d[i] = outputTriggeredValue[i];
            end else begin
                gpoVal_d[i] = outputDefaultValue[i];
            end
            gpoOe_d[i] = pinIsDigital[i] && digitalIsOutput[i] && (outputPushPull[i] || !gpoVal_d[i]);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outValid_q <= 1'b0;
            outData_q <= '0;
            notifyOut_q <= 1'b1;
            notifyOe_q <= 1'b0;
            gpoVal_q <= '0;
            gpoOe_q <= '0;
        end else begin
            outValid_q <= outValid_d;
            outData_q <= outData_d;
            notifyOut_q <= notifyOut_d;
            notifyOe_q <= notifyOe_d;
            gpoVal_q <= gpoVal_d;
            gpoOe_q <= gpoOe_d;
        end
    end

    assign outValid = outValid_q;
    assign outData = outData_q;
    assign notifyOut = notifyOut_q;
    assign notifyOe = notifyOe_q;
    assign gpioOut = gpoVal_q;
    assign gpioOe = gpoOe_q;

    // ************************************************************
    // Statistics
    // ************************************************************
    wcel_pkg::wcel_conv_s pend_q, pend_d;
    wcel_pkg::wcel_statwr_s lastWr_q, lastWr_d;
    logic [wcel_pkg::NCH-1:0] statValid_q, statValid_d;
    wcel_pkg::wcel_stat_s memRd, base;
    logic memWe;

    always_comb begin
        pend_d = conv;
        pend_d.valid = conv.valid && statisticsEnable && !pinIsDigital[conv.channel] && !statisticsEnableWrite;
        // Forward the entry written last cycle; the registered read still returns the old one
        base = (lastWr_q.valid && lastWr_q.channel == pend_q.channel) ? lastWr_q.data : memRd;
        memWe = pend_q.valid && statisticsEnable && !statisticsEnableWrite;
        lastWr_d.valid = memWe;
        lastWr_d.channel = pend_q.channel;
        lastWr_d.data.lastCode = pend_q.code;
        if (statValid_q[pend_q.channel]) begin
            lastWr_d.data.minCode = (pend_q.code < base.minCode) ? pend_q.code : base.minCode;
            lastWr_d.data.maxCode = (pend_q.code > base.maxCode) ? pend_q.code : base.maxCode;
        end else begin
            lastWr_d.data.minCode = pend_q.code;
            lastWr_d.data.maxCode = pend_q.code;
        end
        statValid_d = statValid_q;
        if (statisticsEnableWrite) begin
            statValid_d = '0;
        end else if (memWe) begin
            statValid_d[pend_q.channel] = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_q <= '0;
            lastWr_q <= '0;
            statValid_q <= '0;
        end else begin
            pend_q <= pend_d;
            lastWr_q <= lastWr_d;
            statValid_q <= statValid_d;
        end
    end

    assign statValid = statValid_q;

    wcel_stat_mem statMem (
        .clk(clk),
        .wrEn(memWe),
        .wrAddr(pend_q.channel),
        .wrData(lastWr_d.data),
        .rdAddrA(conv.channel),
        .rdDataA(memRd),
        .rdAddrB(statReadChannel),
        .rdDataB(statReadData)
    );
endmodule
`default_nettype wire

// >>> bench/wcel_host_model.sv
`default_nettype none
module wcel_host_model (
    input wire logic notifyOut, // Notify value
    input wire logic notifyOe, // Notify enable
    input wire logic [7:0] gpioOut, // Pin values
    input wire logic [7:0] gpioOe, // Pin enables
    input wire logic [7:0] extLevel, // Host pin drive
    output logic notifyLine, // Notify wire
    output logic [7:0] pinLevel // Channel pins
);
    // Pull-up on the notify line; released channel pins follow extLevel, so none keeps its old value
    assign notifyLine = notifyOe ? notifyOut : 1'b1;
    assign pinLevel = (gpioOe & gpioOut) | (~gpioOe & extLevel);
endmodule
`default_nettype wire

// >>> bench/wcel_event_monitor.sv
`default_nettype none
module wcel_event_monitor (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire wcel_pkg::wcel_conv_s conv, // Result in
    input wire logic [1:0] appendSelect, // Nibble
    input wire logic inputCrcError, // CRC flag
    input wire logic windowComparatorEnable, // Enable
    input wire logic [7:0] regionSelect, // Region
    input wire logic [7:0] pinIsDigital, // Digital
    input wire logic [7:0] digitalIsOutput, // Output
    input wire logic [7:0] highFlagClear, // Clear
    input wire logic [7:0] lowFlagClear, // Clear
    input wire logic [7:0] notifyChannelSelect, // Select
    input wire logic notifyPushPull, // Drive
    input wire logic [7:0][7:0] outputTriggerSelect, // Triggers
    input wire logic [7:0] outputDefaultValue, // Idle
    input wire logic [7:0] outputTriggeredValue, // Event
    input wire logic [7:0] outputTriggerEnable, // Enable
    input wire logic [7:0] gpioIn, // Pins
    input wire logic [7:0] gpioOut, // Values
    input wire logic [7:0] gpioOe, // Enables
    input wire logic notifyOut, // Notify
    input wire logic notifyOe, // Notify oe
    input wire logic [7:0] highFlag, // High
    input wire logic [7:0] lowFlag, // Low
    input wire logic [7:0] eventFlag, // Combined
    input wire logic outValid, // Strobe
    input wire logic [15:0] outData // Word
);
    logic [7:0] gpoWant;
    wire logic [7:0] pinLvl = (gpioOe & gpioOut) | ~gpioOe;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            gpoWant[i] = (outputTriggerEnable[i] && |(eventFlag & outputTriggerSelect[i])) ?
                outputTriggeredValue[i] : outputDefaultValue[i];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence sRise;
        pinIsDigital[5] && !digitalIsOutput[5] && !regionSelect[5] && $rose(gpioIn[5]);
    endsequence
    sequence sFall;
        pinIsDigital[5] && !digitalIsOutput[5] && regionSelect[5] && $fell(gpioIn[5]);
    endsequence
    sequence sStatus;
        conv.valid && appendSelect == wcel_pkg::APPEND_FLAGS;
    endsequence
    AST_STATUS: assert property (sStatus |=> outData == {$past(conv.code), wcel_pkg::STATUS_FIXED,
        $past(inputCrcError), $past(|eventFlag)}) else $error("status nibble wrong");
    AST_VALID: assert property (1 |=> outValid == $past(conv.valid)) else $error("output strobe wrong");
    AST_COMBINED: assert property (eventFlag == (highFlag | lowFlag)) else $error("combined flag wrong");
    AST_NOTIFY: assert property (1 |=> notifyOut == !$past(|(eventFlag & notifyChannelSelect)))
        else $error("notify level wrong");
    AST_NOTIFY_DRIVE: assert property (1 |=> notifyOe == ($past(notifyPushPull) || !notifyOut))
        else $error("notify drive wrong");
    AST_GPO_LEVEL: assert property (1 |=> ((pinLvl ^ $past(gpoWant)) & $past(pinIsDigital & digitalIsOutput)) == 8'h00)
        else $error("output pin level wrong");
    AST_GPO_IDLE: assert property (1 |=> (gpioOe & ~$past(pinIsDigital & digitalIsOutput)) == 8'h00)
        else $error("non-output pin driven");
    AST_HOLD: assert property (1 |=> (~highFlag & $past(highFlag & ~highFlagClear)) == 8'h00 &&
        (~lowFlag & $past(lowFlag & ~lowFlagClear)) == 8'h00) else $error("flag dropped");
    AST_DISABLED: assert property (conv.valid && !windowComparatorEnable && !pinIsDigital[conv.channel] &&
        !eventFlag[conv.channel] |=> !eventFlag[$past(conv.channel)]) else $error("flag set while off");
    AST_RISE: assert property (sRise |-> ##[1:5] highFlag[5]) else $error("rising edge missed");
    AST_FALL: assert property (sFall |-> ##[1:5] lowFlag[5]) else $error("falling edge missed");
endmodule
bind wcel_event_logic wcel_event_monitor mon (.*);
`default_nettype wire

// >>> bench/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [2:0] ch;
        logic [11:0] hi;
        logic [11:0] lo;
        logic rgn;
        logic [11:0] code;
        logic [1:0] hl;
    } wcel_row_s;
    localparam wcel_row_s ROWS [6] = '{
        '{3'h0, 12'hFFF, 12'h000, 1'b0, 12'h800, 2'h0},
        '{3'h1, 12'h800, 12'h100, 1'b0, 12'h801, 2'h2},
        '{3'h2, 12'h800, 12'h100, 1'b0, 12'h800, 2'h0},
        '{3'h3, 12'h800, 12'h100, 1'b0, 12'h0FF, 2'h1},
        '{3'h4, 12'h800, 12'h100, 1'b1, 12'h400, 2'h3},
        '{3'h6, 12'h800, 12'h100, 1'b1, 12'h0FF, 2'h0}};
    logic clk = 1'b0, rst = 1'b1, inputCrcError = 1'b0, windowComparatorEnable = 1'b1, cfgWrite = 1'b0;
    logic notifyPushPull = 1'b0, statisticsEnable = 1'b0, statisticsEnableWrite = 1'b0;
    logic [1:0] appendSelect = 2'h0;
    logic [2:0] cfgChannel = 3'h0, statReadChannel = 3'h0;
    wcel_pkg::wcel_conv_s conv = '0;
    wcel_pkg::wcel_chcfg_s cfgData = wcel_pkg::CHCFG_RST;
    logic [7:0] regionSelect = 8'h00, pinIsDigital = 8'h00, digitalIsOutput = 8'h00, outputPushPull = 8'h00;
    logic [7:0] highFlagClear = 8'h00, lowFlagClear = 8'h00, notifyChannelSelect = 8'h00, extLevel = 8'hFF;
    logic [7:0] outputDefaultValue = 8'h00, outputTriggeredValue = 8'h00, outputTriggerEnable = 8'h00;
    logic [7:0][7:0] outputTriggerSelect = '0;
    wire logic [7:0] gpioIn, gpioOut, gpioOe, highFlag, lowFlag, eventFlag, statValid;
    wire logic notifyOut, notifyOe, outValid, notifyLine;
    wire logic [15:0] outData;
    wcel_pkg::wcel_stat_s statReadData;
    int failures = 0;
    int comparisons = 0;
    wcel_event_logic DUT (.*);
    wcel_host_model host (.notifyOut, .notifyOe, .gpioOut, .gpioOe, .extLevel, .notifyLine, .pinLevel(gpioIn));
    always #2.5 clk = ~clk;
    // ****************************************
    // Tasks
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [35:0] got, input logic [35:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    task automatic convert(input logic [2:0] ch, input logic [11:0] code);
        conv = '{1'b1, ch, code};
        tick(1);
        conv.valid = 1'b0;
        tick(1);
    endtask
    task automatic cfg(input logic [2:0] ch, input logic [11:0] hi, input logic [11:0] lo, input logic [3:0] n);
        cfgChannel = ch;
        cfgData = '{hi, lo, 4'h0, n};
        cfgWrite = 1'b1;
        tick(1);
        cfgWrite = 1'b0;
        tick(1);
    endtask
    task automatic clear;
        highFlagClear = 8'hFF;
        lowFlagClear = 8'hFF;
        tick(1);
        highFlagClear = 8'h00;
        lowFlagClear = 8'h00;
        tick(1);
    endtask
    task automatic waitEdge(input logic hi);
        int n;
        n = 0;
        while (((hi ? highFlag[5] : lowFlag[5]) !== 1'b1) && n < 8) begin
            tick(1);
            n++;
        end
        check(n < 8, 1'b1, "edge flag");
    endtask
    task automatic close_out;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        #100000;
        failures++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        tick(1);
        check({highFlag, lowFlag}, 36'h0_0000_0000, "reset flags");
        check({notifyLine, notifyOe, gpioOe, outData}, 36'h0_0200_0000, "reset pins");
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            if (ROWS[i].ch != 3'h0) begin
                cfg(ROWS[i].ch, ROWS[i].hi, ROWS[i].lo, 4'h0);
            end
            regionSelect[ROWS[i].ch] = ROWS[i].rgn;
            convert(ROWS[i].ch, ROWS[i].code);
            check({highFlag[ROWS[i].ch], lowFlag[ROWS[i].ch]}, ROWS[i].hl, "row flags");
        end
        $display("test rows done");
        clear();
        cfg(3'h1, 12'h800, 12'h100, 4'h2);
        convert(3'h1, 12'h100);
        convert(3'h1, 12'h900);
        convert(3'h1, 12'h100);
        convert(3'h1, 12'h900);
        convert(3'h1, 12'h900);
        check(highFlag[1], 1'b0, "count early");
        convert(3'h1, 12'h900);
        check(highFlag[1], 1'b1, "count reached");
        $display("test count done");
        appendSelect = wcel_pkg::APPEND_FLAGS;
        inputCrcError = 1'b1;
        convert(3'h0, 12'hABC);
        check(outData, 16'hABCB, "status set");
        inputCrcError = 1'b0;
        clear();
        convert(3'h0, 12'h123);
        check(outData, 16'h1238, "status clear");
        appendSelect = wcel_pkg::APPEND_CHID;
        conv = '{1'b1, 3'h3, 12'h456};
        tick(1);
        check({outValid, outData}, 17'h1_4563, "channel id");
        conv.valid = 1'b0;
        tick(1);
        check(outValid, 1'b0, "strobe one cycle");
        $display("test status done");
        cfg(3'h1, 12'h800, 12'h100, 4'h0);
        windowComparatorEnable = 1'b0;
        convert(3'h1, 12'h900);
        check(highFlag[1], 1'b0, "disabled");
        windowComparatorEnable = 1'b1;
        convert(3'h1, 12'h900);
        notifyChannelSelect = 8'h02;
        tick(2);
        check({notifyLine, notifyOe}, 2'b01, "notify on");
        notifyChannelSelect = 8'h01;
        notifyPushPull = 1'b1;
        tick(2);
        check({notifyLine, notifyOe}, 2'b11, "notify off");
        $display("test notify done");
        pinIsDigital[7] = 1'b1;
        digitalIsOutput[7] = 1'b1;
        outputTriggerSelect[7] = 8'h02;
        outputTriggerEnable[7] = 1'b1;
        outputTriggeredValue[7] = 1'b1;
        tick(2);
        check(gpioIn[7], 1'b1, "triggered");
        clear();
        tick(1);
        check(gpioIn[7], 1'b0, "default");
        outputTriggerEnable[7] = 1'b0;
        convert(3'h1, 12'h900);
        tick(1);
        check(gpioIn[7], 1'b0, "update off");
        $display("test outputs done");
        pinIsDigital[5] = 1'b1;
        extLevel[5] = 1'b0;
        tick(4);
        clear();
        extLevel[5] = 1'b1;
        waitEdge(1'b1);
        regionSelect[5] = 1'b1;
        clear();
        extLevel[5] = 1'b0;
        waitEdge(1'b0);
        $display("test edges done");
        statisticsEnable = 1'b1;
        statisticsEnableWrite = 1'b1;
        tick(1);
        statisticsEnableWrite = 1'b0;
        convert(3'h2, 12'h300);
        convert(3'h2, 12'h100);
        convert(3'h2, 12'h200);
        statisticsEnable = 1'b0;
        convert(3'h2, 12'hFFF);
        statReadChannel = 3'h2;
        tick(2);
        check(statReadData, 36'h1_0030_0200, "stats");
        check(statValid[2], 1'b1, "stat valid");
        statisticsEnable = 1'b1;
        statisticsEnableWrite = 1'b1;
        tick(1);
        statisticsEnableWrite = 1'b0;
        tick(1);
        check(statValid[2], 1'b0, "reinit valid");
        check(statReadData, 36'h1_0030_0200, "reinit kept");
        $display("test statistics done");
        close_out();
    end
endmodule
`default_nettype wire
